// file: design/uart_select_cfg.svh
// Register codes, field positions and timing figures for the register selector
`ifndef UART_SELECT_CFG_SVH
`define UART_SELECT_CFG_SVH
`define CODE_HOLD 3'h0
`define CODE_IEN 3'h1
`define CODE_ISRC 3'h2
`define CODE_FMT 3'h3
`define CODE_HCTL 3'h4
`define CODE_LSTAT 3'h5
`define CODE_HSTAT 3'h6
`define CODE_SCR 3'h7
`define FMT_KEY 8'hBF
`define FMT_DIV_BIT 7
`define EFR_ENH_BIT 4
`define HCTL_PRESCALE_BIT 7
`define HCTL_THRESH_EN_BIT 6
`define HCTL_LOOP_BIT 4
`define HCTL_RDY_EN_BIT 2
`define QCTL_FIFO_EN_BIT 0
`define QCTL_TXTRIG_LO 4
`define QCTL_TXTRIG_HI 5
`define RDY_TXA_BIT 0
`define RDY_TXB_BIT 1
`define RDY_RXA_BIT 4
`define RDY_RXB_BIT 5
`define BAUD_OVERSAMPLE 16
`define CLK_PERIOD_PS 8000
`define REG_RESET 8'h00
`define DIV_RESET 16'h0001
`endif

// file: design/uart_select_pkg.sv
// Types shared by the register selector and its helpers
package uart_select_pkg;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] code;
        logic [7:0] wdata;
    } host_access_t;

    typedef struct packed {
        logic tx_ready_a;
        logic tx_ready_b;
        logic rx_ready_a;
        logic rx_ready_b;
    } queue_ready_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_WAIT = 3'b010,
        RX_LOADED = 3'b100
    } rx_state_t;
endpackage : uart_select_pkg

// file: design/baud_tick_gen.sv
// Sixteen-times baud tick generator from the programmed divisor
`include "uart_select_cfg.svh"
module baud_tick_gen (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Divisor
    input wire logic [15:0] divisor,
    // Tick out
    output logic tick
);
    import uart_select_pkg::*;
    logic [15:0] count_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_q <= 16'h0000;
            tick <= 1'b0;
        end else if (count_q == 16'h0000) begin
            // Divisor zero treated as one so the tick never stops
            count_q <= (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
            tick <= 1'b1;
        end else begin
            count_q <= count_q - 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule : baud_tick_gen

// file: design/rx_hold_slot.sv
// Single receive holding slot with the non-queued load delay
`include "uart_select_cfg.svh"
module rx_hold_slot (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Control
    input wire logic queue_mode,
    input wire logic baud_tick,
    // Incoming byte
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    // Host side
    input wire logic take,
    output logic available,
    output logic [7:0] hold_byte
);
    import uart_select_pkg::*;
    rx_state_t state_q;
    logic [7:0] pend_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= RX_IDLE;
            pend_q <= `REG_RESET;
            hold_byte <= `REG_RESET;
        end else begin
            unique case (state_q)
                RX_IDLE: begin
                    if (in_valid && queue_mode) begin
                        hold_byte <= in_byte;
                        state_q <= RX_LOADED;
                    end else if (in_valid) begin
                        pend_q <= in_byte;
                        state_q <= RX_WAIT;
                    end
                end
                RX_WAIT: begin
                    // Status already shows data; byte lands one baud tick later
                    if (baud_tick) begin
                        hold_byte <= pend_q;
                        state_q <= RX_LOADED;
                    end
                end
                RX_LOADED: begin
                    // New byte overwrites, as a single slot has no room
                    if (in_valid) begin
                        if (queue_mode) begin
                            hold_byte <= in_byte;
                        end else begin
                            pend_q <= in_byte;
                            state_q <= RX_WAIT;
                        end
                    end else if (take) begin
                        state_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    assign available = (state_q != RX_IDLE);
endmodule : rx_hold_slot

// file: design/uart_register_select.sv
// One channel's register selection and access gating
`include "uart_select_cfg.svh"
module uart_register_select (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Host bus, strobes active low, asynchronous and synchronised here
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic own_select_n,
    input wire logic other_select_n,
    output logic [7:0] rdata,
    output logic rdata_oe_n,
    // Channel status inputs from the rest of the transceiver
    input wire logic [7:0] line_status_in,
    input wire logic [7:0] handshake_status_in,
    input wire logic [7:0] interrupt_source_in,
    input wire uart_select_pkg::queue_ready_t queue_ready_in,
    // Received byte from the shift register
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    // Transmit side, control, receive flag and baud tick outputs
    output logic tx_load,
    output logic [7:0] tx_byte,
    output logic queue_control_strobe,
    output logic [7:0] queue_control,
    output logic [7:0] interrupt_enables,
    output logic [7:0] frame_format,
    output logic [7:0] handshake_control,
    output logic [7:0] enhanced_features,
    output logic [15:0] divisor,
    output logic [7:0] flow_resume_char_first,
    output logic [7:0] flow_resume_char_second,
    output logic [7:0] flow_stop_char_first,
    output logic [7:0] flow_stop_char_second,
    output logic [7:0] flow_threshold_levels,
    output logic [7:0] queue_trigger_levels,
    output logic rx_available,
    output logic baud_tick
);
    import uart_select_pkg::*;

    // Two-stage synchronisers for the asynchronous bus pins
    logic [1:0] rd_sync_q;
    logic [1:0] wr_sync_q;
    logic [1:0] cs_sync_q;
    logic [1:0] cso_sync_q;
    logic rd_prev_q;
    logic wr_prev_q;
    logic [2:0] addr_s1_q;
    logic [2:0] addr_q;
    logic [7:0] wd_s1_q;
    logic [7:0] wd_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_sync_q <= 2'h3;
            wr_sync_q <= 2'h3;
            cs_sync_q <= 2'h3;
            cso_sync_q <= 2'h3;
            rd_prev_q <= 1'b1;
            wr_prev_q <= 1'b1;
            addr_s1_q <= 3'h0;
            addr_q <= 3'h0;
            wd_s1_q <= `REG_RESET;
            wd_q <= `REG_RESET;
        end else begin
            rd_sync_q <= {rd_sync_q[0], rd_n};
            wr_sync_q <= {wr_sync_q[0], wr_n};
            cs_sync_q <= {cs_sync_q[0], own_select_n};
            cso_sync_q <= {cso_sync_q[0], other_select_n};
            rd_prev_q <= rd_sync_q[1];
            wr_prev_q <= wr_sync_q[1];
            addr_s1_q <= addr;
            addr_q <= addr_s1_q;
            wd_s1_q <= wdata;
            wd_q <= wd_s1_q;
        end
    end

    // Falling edge of a synchronised active-low strobe
    function automatic logic strobe_fell(input logic now_n, input logic prev_n);
        strobe_fell = !now_n && prev_n;
    endfunction : strobe_fell

    host_access_t acc;
    logic own_sel;
    logic both_sel;
    assign own_sel = !cs_sync_q[1];
    assign both_sel = !cs_sync_q[1] && !cso_sync_q[1];
    // Access acts on the falling edge of a strobe; one action per strobe
    assign acc.rd = strobe_fell(rd_sync_q[1], rd_prev_q) && own_sel;
    assign acc.wr = strobe_fell(wr_sync_q[1], wr_prev_q) && own_sel && !both_sel;
    assign acc.code = addr_q;
    assign acc.wdata = wd_q;

    // Gating conditions
    logic div_mode;
    logic key_mode;
    logic thresh_mode;
    logic ready_mode;
    logic enh_on;
    assign enh_on = enhanced_features[`EFR_ENH_BIT];
    assign key_mode = (frame_format == `FMT_KEY);
    assign div_mode = frame_format[`FMT_DIV_BIT];
    assign thresh_mode = enhanced_features[`EFR_ENH_BIT]
        && handshake_control[`HCTL_THRESH_EN_BIT];
    assign ready_mode = both_sel && handshake_control[`HCTL_RDY_EN_BIT]
        && !handshake_control[`HCTL_LOOP_BIT];

    function automatic logic hit(input host_access_t a, input logic [2:0] code);
        hit = (a.code == code);
    endfunction : hit

    // Key mode takes 010 and 100-111; divisor mode takes 000-001
    logic key_upper;
    assign key_upper = key_mode && acc.code[2];

    // Frame format
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            frame_format <= `REG_RESET;
        end else if (acc.wr && hit(acc, `CODE_FMT)) begin
            frame_format <= acc.wdata;
        end
    end

    // Divisor latch takes codes 000/001 and shares 001 with interrupt enables
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            divisor <= `DIV_RESET;
            interrupt_enables <= `REG_RESET;
        end else if (acc.wr && div_mode) begin
            if (hit(acc, `CODE_HOLD)) begin
                divisor[7:0] <= acc.wdata;
            end
            if (hit(acc, `CODE_IEN)) begin
                divisor[15:8] <= acc.wdata;
            end
        end else if (acc.wr && hit(acc, `CODE_IEN)) begin
            interrupt_enables <= acc.wdata;
        end
    end

    // Transmit byte load
    logic tx_write;
    assign tx_write = acc.wr && !div_mode && hit(acc, `CODE_HOLD);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_load <= 1'b0;
            tx_byte <= `REG_RESET;
        end else begin
            tx_load <= tx_write;
            if (tx_write) begin
                tx_byte <= acc.wdata;
            end
        end
    end

    // Queue control (write-only) and enhanced features at 010
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            queue_control <= `REG_RESET;
            queue_control_strobe <= 1'b0;
            enhanced_features <= `REG_RESET;
        end else begin
            queue_control_strobe <= 1'b0;
            if (acc.wr && hit(acc, `CODE_ISRC) && key_mode) begin
                enhanced_features <= acc.wdata;
            end else if (acc.wr && hit(acc, `CODE_ISRC)) begin
                queue_control_strobe <= 1'b1;
                queue_control[7:6] <= acc.wdata[7:6];
                queue_control[3:0] <= acc.wdata[3:0];
                if (enh_on) begin
                    queue_control[`QCTL_TXTRIG_HI:`QCTL_TXTRIG_LO] <=
                        acc.wdata[`QCTL_TXTRIG_HI:`QCTL_TXTRIG_LO];
                end
            end
        end
    end

    // Handshake control, prescaler bit guarded
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            handshake_control <= `REG_RESET;
        end else if (acc.wr && hit(acc, `CODE_HCTL) && !key_mode) begin
            handshake_control[6:0] <= acc.wdata[6:0];
            if (enh_on) begin
                handshake_control[`HCTL_PRESCALE_BIT] <=
                    acc.wdata[`HCTL_PRESCALE_BIT];
            end
        end
    end

    // Key-mode flow characters
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flow_resume_char_first <= `REG_RESET;
            flow_resume_char_second <= `REG_RESET;
            flow_stop_char_first <= `REG_RESET;
            flow_stop_char_second <= `REG_RESET;
        end else if (acc.wr && key_upper) begin
            unique case (acc.code)
                `CODE_HCTL: flow_resume_char_first <= acc.wdata;
                `CODE_LSTAT: flow_resume_char_second <= acc.wdata;
                `CODE_HSTAT: flow_stop_char_first <= acc.wdata;
                default: flow_stop_char_second <= acc.wdata;
            endcase
        end
    end

    // Threshold registers; key mode owns these codes first
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flow_threshold_levels <= `REG_RESET;
            queue_trigger_levels <= `REG_RESET;
        end else if (acc.wr && thresh_mode && !key_mode) begin
            if (hit(acc, `CODE_HSTAT)) begin
                flow_threshold_levels <= acc.wdata;
            end
            if (hit(acc, `CODE_SCR)) begin
                queue_trigger_levels <= acc.wdata;
            end
        end
    end

    // Scratch byte, only when no gated register owns 111
    logic [7:0] scratch_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scratch_q <= `REG_RESET;
        end else if (acc.wr && hit(acc, `CODE_SCR) && !key_mode && !thresh_mode) begin
            scratch_q <= acc.wdata;
        end
    end

    // Baud tick and receive slot
    baud_tick_gen u_baud (
        .clock(clock),
        .nrst(nrst),
        .divisor(divisor),
        .tick(baud_tick)
    );

    logic [7:0] hold_byte;
    logic rx_take;
    assign rx_take = acc.rd && !div_mode && hit(acc, `CODE_HOLD);
    rx_hold_slot u_slot (
        .clock(clock),
        .nrst(nrst),
        .queue_mode(queue_control[`QCTL_FIFO_EN_BIT]),
        .baud_tick(baud_tick),
        .in_valid(rx_valid),
        .in_byte(rx_byte),
        .take(rx_take),
        .available(rx_available),
        .hold_byte(hold_byte)
    );

    // Read multiplexer, gated register wins over normal one
    function automatic logic [7:0] ready_byte(input queue_ready_t r);
        logic [7:0] v;
        v = 8'h00;
        v[`RDY_TXA_BIT] = r.tx_ready_a;
        v[`RDY_TXB_BIT] = r.tx_ready_b;
        v[`RDY_RXA_BIT] = r.rx_ready_a;
        v[`RDY_RXB_BIT] = r.rx_ready_b;
        ready_byte = v;
    endfunction : ready_byte

    logic [7:0] read_d;
    logic rd_any;
    always_comb begin
        read_d = 8'h00;
        unique case (acc.code)
            `CODE_HOLD: read_d = div_mode ? divisor[7:0] : hold_byte;
            `CODE_IEN: read_d = div_mode ? divisor[15:8] : interrupt_enables;
            `CODE_ISRC: read_d = key_mode ? enhanced_features : interrupt_source_in;
            `CODE_FMT: read_d = frame_format;
            `CODE_HCTL: read_d = key_mode ? flow_resume_char_first : handshake_control;
            `CODE_LSTAT: read_d = key_mode ? flow_resume_char_second : line_status_in;
            `CODE_HSTAT: begin
                if (key_mode) begin
                    read_d = flow_stop_char_first;
                end else if (thresh_mode) begin
                    read_d = flow_threshold_levels;
                end else begin
                    read_d = handshake_status_in;
                end
            end
            default: begin
                if (ready_mode) begin
                    read_d = ready_byte(queue_ready_in);
                end else if (key_mode) begin
                    read_d = flow_stop_char_second;
                end else if (thresh_mode) begin
                    read_d = queue_trigger_levels;
                end else begin
                    read_d = scratch_q;
                end
            end
        endcase
    end

    // Queue ready read is allowed with both selects low
    assign rd_any = strobe_fell(rd_sync_q[1], rd_prev_q) && (own_sel || both_sel);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= `REG_RESET;
        end else if (rd_any) begin
            rdata <= read_d;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_oe_n <= 1'b1;
        end else begin
            rdata_oe_n <= !(!rd_sync_q[1] && own_sel);
        end
    end
endmodule : uart_register_select

// file: test/host_bus_model.sv
// Host processor model driving one channel's parallel register bus
module host_bus_model (
    // Clock
    input wire logic clock,
    // Bus towards the device
    output logic [2:0] addr,
    output logic [7:0] wdata,
    output logic rd_n,
    output logic wr_n,
    output logic own_select_n,
    output logic other_select_n,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr = 3'h0;
        wdata = 8'h00;
        rd_n = 1'b1;
        wr_n = 1'b1;
        own_select_n = 1'b1;
        other_select_n = 1'b1;
    end
    // Strobe low six clocks: read data lands by the fourth
    task automatic access(input logic is_rd, input logic both, input logic [2:0] code,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        addr <= code;
        wdata <= d;
        own_select_n <= 1'b0;
        other_select_n <= !both;
        @(posedge clock);
        rd_n <= !is_rd;
        wr_n <= is_rd;
        repeat (6) @(posedge clock);
        q = rdata;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        @(posedge clock);
        own_select_n <= 1'b1;
        other_select_n <= 1'b1;
        // Released lines show no stale value
        addr <= ~code;
        wdata <= ~d;
        repeat (3) @(posedge clock);
    endtask : access
endmodule : host_bus_model

// file: test/uart_register_select_chk.sv
// Port-level assertions for the register selector
module uart_register_select_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Host bus
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic own_select_n,
    input wire logic other_select_n,
    input wire logic rdata_oe_n,
    // Watched outputs and the receive valid input
    input wire logic tx_load,
    input wire logic [7:0] tx_byte,
    input wire logic [7:0] queue_control,
    input wire logic queue_control_strobe,
    input wire logic [7:0] frame_format,
    input wire logic [7:0] handshake_control,
    input wire logic [7:0] enhanced_features,
    input wire logic [15:0] divisor,
    input wire logic [7:0] flow_threshold_levels,
    input wire logic rx_valid,
    input wire logic rx_available
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    logic wr_q;
    logic rd_q;
    logic wr_go;
    logic wr_both;
    logic rd_go;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_q <= 1'b1;
            rd_q <= 1'b1;
        end else begin
            wr_q <= wr_n;
            rd_q <= rd_n;
        end
    end
    assign wr_go = wr_q && !wr_n && !own_select_n && other_select_n;
    assign wr_both = wr_q && !wr_n && !own_select_n && !other_select_n;
    assign rd_go = rd_q && !rd_n && !own_select_n;
    a_tx_write_load: assert property (wr_go && addr == 3'h0 && !frame_format[7]
        |-> ##[2:4] tx_load && tx_byte == wdata) else $error("transmit write lost");
    a_tx_load_gate: assert property (tx_load |-> addr == 3'h0 && !frame_format[7]
        ##1 !tx_load) else $error("stray transmit load");
    a_format_write: assert property (wr_go && addr == 3'h3
        |-> ##[2:4] frame_format == wdata) else $error("format write lost");
    a_div_low_write: assert property (wr_go && addr == 3'h0 && frame_format[7]
        |-> ##[2:4] divisor[7:0] == wdata) else $error("divisor low lost");
    a_div_high_write: assert property (wr_go && addr == 3'h1 && frame_format[7]
        |-> ##[2:4] divisor[15:8] == wdata) else $error("divisor high lost");
    a_key_efr_write: assert property (wr_go && addr == 3'h2 && frame_format == 8'hBF
        |-> ##[2:4] enhanced_features == wdata) else $error("feature write lost");
    a_thresh_write: assert property (wr_go && addr == 3'h6 && frame_format != 8'hBF
        && enhanced_features[4] && handshake_control[6]
        |-> ##[2:4] flow_threshold_levels == wdata) else $error("threshold write lost");
    a_prescale_lock: assert property (!enhanced_features[4]
        |=> $stable(handshake_control[7])) else $error("prescaler bit changed");
    a_trigger_lock: assert property (!enhanced_features[4]
        |=> $stable(queue_control[5:4])) else $error("trigger field changed");
    a_both_sel_ignored: assert property (wr_both
        |=> (!tx_load && $stable(frame_format)) [*5]) else $error("shared write taken");
    a_read_drive: assert property (rd_go |-> ##[2:4] !rdata_oe_n)
        else $error("read not driven");
    a_rx_flag: assert property (rx_valid |-> ##[1:2] rx_available)
        else $error("receive flag late");
    a_qctl_strobe: assert property (wr_go && addr == 3'h2 && frame_format != 8'hBF
        |-> ##[2:4] queue_control_strobe) else $error("queue control strobe lost");
    a_key_no_strobe: assert property (wr_go && addr == 3'h2 && frame_format == 8'hBF
        |=> (!queue_control_strobe) [*5]) else $error("queue control hit in key mode");
endmodule : uart_register_select_chk

bind uart_register_select uart_register_select_chk chk (.clock, .nrst, .addr, .wdata,
    .rd_n, .wr_n, .own_select_n, .other_select_n, .rdata_oe_n, .tx_load, .tx_byte,
    .queue_control, .queue_control_strobe, .frame_format, .handshake_control,
    .enhanced_features, .divisor,
    .flow_threshold_levels, .rx_valid, .rx_available);

// file: test/uart_register_select_tb.sv
// Self-checking bench for the register selector
`include "uart_select_cfg.svh"
module uart_register_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_select_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] addr;
    logic [15:0] divisor;
    logic [7:0] wdata, rdata, line_status_in, handshake_status_in, interrupt_source_in;
    logic [7:0] rx_byte, tx_byte, queue_control, interrupt_enables, frame_format;
    logic [7:0] handshake_control, enhanced_features, flow_resume_char_first;
    logic [7:0] flow_resume_char_second, flow_stop_char_first, flow_stop_char_second;
    logic [7:0] flow_threshold_levels, queue_trigger_levels, q, d, dl, ien;
    logic rd_n, wr_n, own_select_n, other_select_n, rdata_oe_n, rx_valid, tx_load;
    logic queue_control_strobe, rx_available, baud_tick;
    queue_ready_t queue_ready_in;
    logic [7:0] fc [8];
    logic [15:0] seed = 16'h4B32;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;
    uart_register_select uut (.clock, .nrst, .addr, .wdata, .rd_n, .wr_n, .own_select_n,
        .other_select_n, .rdata, .rdata_oe_n, .line_status_in, .handshake_status_in,
        .interrupt_source_in, .queue_ready_in, .rx_valid, .rx_byte, .tx_load, .tx_byte,
        .queue_control_strobe, .queue_control, .interrupt_enables, .frame_format,
        .handshake_control, .enhanced_features, .divisor, .flow_resume_char_first,
        .flow_resume_char_second, .flow_stop_char_first, .flow_stop_char_second,
        .flow_threshold_levels, .queue_trigger_levels, .rx_available, .baud_tick);
    host_bus_model host (.clock, .addr, .wdata, .rd_n, .wr_n, .own_select_n,
        .other_select_n, .rdata);
    always #4 clock = ~clock;
    function automatic logic [7:0] nx();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction : nx
    function automatic logic [7:0] ready_byte(input queue_ready_t r);
        return {2'b00, r.rx_ready_b, r.rx_ready_a, 2'b00, r.tx_ready_b, r.tx_ready_a};
    endfunction : ready_byte
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] c, input logic [7:0] v);
        host.access(1'b0, 1'b0, c, v, q);
    endtask : wr
    task automatic rd(input logic [2:0] c, input logic both = 1'b0);
        host.access(1'b1, both, c, 8'h00, q);
    endtask : rd
    task automatic wrc(input logic [2:0] c, input logic [7:0] v, input logic [7:0] exp);
        wr(c, v);
        rd(c);
        check(q, exp);
    endtask : wrc
    task automatic rx_send(input logic [7:0] v);
        @(posedge clock);
        rx_byte <= v;
        rx_valid <= 1'b1;
        @(posedge clock);
        rx_valid <= 1'b0;
        repeat (3) @(posedge clock);
        check(rx_available, 1'b1);
    endtask : rx_send
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    // Ceiling well above the roughly two thousand cycles the sequence takes
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        line_status_in = 8'h00;
        handshake_status_in = 8'h00;
        interrupt_source_in = 8'h00;
        queue_ready_in = 4'h0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        check(divisor, `DIV_RESET);
        check(frame_format, `REG_RESET);
        for (int i = 0; i < 6; i++) begin
            line_status_in <= nx();
            handshake_status_in <= nx();
            interrupt_source_in <= nx();
            d = nx();
            queue_ready_in <= d[3:0];
            d = nx() & 8'h7F;
            wrc(3'h3, d, d);
            ien = nx();
            wrc(3'h1, ien, ien);
            check(interrupt_enables, ien);
            d = nx();
            wrc(3'h7, d, d);
            d = nx();
            wrc(3'h4, d, {1'b0, d[6:0]});
            d = nx();
            wr(3'h0, d);
            check(tx_byte, d);
            d = nx();
            wr(3'h2, d);
            check(queue_control, d & 8'hCF);
            wr(3'h5, nx());
            rd(3'h5);
            check(q, line_status_in);
            rd(3'h6);
            check(q, handshake_status_in);
            rd(3'h2);
            check(q, interrupt_source_in);
        end
        wr(3'h3, 8'h83);
        dl = nx() | 8'h40;
        wrc(3'h0, dl, dl);
        d = nx();
        wrc(3'h1, d, d);
        check(divisor, {d, dl});
        wr(3'h1, 8'h00);
        wr(3'h3, 8'h03);
        rd(3'h1);
        check(q, ien);
        wr(3'h3, `FMT_KEY);
        wrc(3'h2, 8'h10, 8'h10);
        for (int c = 4; c < 8; c++) begin
            d = nx();
            fc[c] = d;
            wrc(3'(c), d, d);
        end
        check(flow_stop_char_second, d);
        check({flow_resume_char_first, flow_resume_char_second}, {fc[4], fc[5]});
        check(flow_stop_char_first, fc[6]);
        rd(3'h3);
        check(q, `FMT_KEY);
        wr(3'h3, 8'h03);
        check(enhanced_features, 8'h10);
        wrc(3'h4, 8'hC4, 8'hC4);
        d = nx();
        wrc(3'h6, d, d);
        check(flow_threshold_levels, d);
        d = nx();
        wrc(3'h7, d, d);
        check(queue_trigger_levels, d);
        wr(3'h2, 8'h30);
        check(queue_control, 8'h30);
        rd(3'h7, 1'b1);
        check(q, ready_byte(queue_ready_in));
        wr(3'h4, 8'h54);
        rd(3'h7, 1'b1);
        check(q, d);
        host.access(1'b0, 1'b1, 3'h3, 8'h55, q);
        rd(3'h3);
        check(q, 8'h03);
        n = 0;
        while (baud_tick !== 1'b1) @(posedge clock);
        @(posedge clock);
        while (baud_tick !== 1'b1) begin
            n++;
            @(posedge clock);
        end
        check(16'(n + 1), dl);
        wr(3'h2, 8'h00);
        d = nx();
        rx_send(d);
        // Host side waits one baud-clock period before taking the byte
        repeat (dl + 2) @(posedge clock);
        rd(3'h0);
        check(q, d);
        check(rx_available, 1'b0);
        wr(3'h2, 8'h01);
        d = nx();
        rx_send(d);
        rd(3'h0);
        check(q, d);
        summarize();
    end
endmodule : uart_register_select_tb
